// File: design/rfid_tag_pkg.sv
// Shared constants and types for the passive tag controller
package rfid_tag_pkg;

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned HALF_BIT_NS = 7000;
    // Each Manchester half lasts a whole number of cycles, never less than one
    localparam int unsigned HALF_BIT_CYC_RAW = (HALF_BIT_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned HALF_BIT_CYC = (HALF_BIT_CYC_RAW < 1) ? 1 : HALF_BIT_CYC_RAW;
    localparam int unsigned HALF_CNT_W = 9;

    // ------------------------------------------------------------
    // Sleep interval: nominal 100 ms, spread 40 percent either way
    // ------------------------------------------------------------
    localparam int unsigned SLEEP_NOM_MS = 100;
    localparam int unsigned SLEEP_VAR_PCT = 40;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned SLEEP_MIN_CYC = CYC_PER_MS * SLEEP_NOM_MS * (100 - SLEEP_VAR_PCT) / 100;
    localparam int unsigned SLEEP_SPAN_CYC = CYC_PER_MS * SLEEP_NOM_MS * (2 * SLEEP_VAR_PCT) / 100;
    localparam int unsigned SLEEP_W = 24;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [15:0] LFSR_SEED_DEF = 16'hACE1;

    // ------------------------------------------------------------
    // Memory and programming port
    // ------------------------------------------------------------
    localparam int unsigned MEM_BITS = 154;
    localparam int unsigned MEM_PTR_W = 8;
    localparam logic [MEM_PTR_W-1:0] MEM_LAST = 8'h99;
    localparam int unsigned CODE_BITS = 10;
    localparam logic [3:0] CODE_LAST = 4'h9;
    localparam logic [9:0] CODE_ERASE = 10'h1D4;
    localparam logic [9:0] CODE_PROGRAM = 10'h1D2;
    localparam logic [9:0] CODE_READ = 10'h1D6;

    // Pin synchroniser lanes
    localparam int unsigned SY_N = 4;
    localparam int unsigned SY_SUPPLY = 0;
    localparam int unsigned SY_PCLK = 1;
    localparam int unsigned SY_PDATA = 2;
    localparam int unsigned SY_HV = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic last;
        logic data;
    } tx_bit_t;

    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_SLEEP} tx_state_t;
    typedef enum logic [1:0] {PF_CODE, PF_PROGRAM, PF_READ} prog_state_t;
    typedef enum logic [1:0] {MODE_NONE, MODE_ERASE, MODE_PROGRAM, MODE_READ} mode_t;

endpackage

// File: design/bit_buffer.sv
// Small valid/ready FIFO between memory reader and Manchester encoder
`timescale 1ns/1ps
module bit_buffer #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_flush,
    // Fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

    logic [WIDTH-1:0] slot_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0] cnt_ff;
    logic push;
    logic pop;

    // Honest flags: ready drops only when every slot holds a word
    assign o_ready = (cnt_ff != FULL_CNT);
    assign o_valid = (cnt_ff != '0);
    assign o_data = slot_ff[rd_ff];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // Storage needs no reset; occupancy decides what is visible
    always_ff @(posedge i_clk) begin
        if (push) begin
            slot_ff[wr_ff] <= i_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_clk) begin
        if (i_reset || i_flush) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == LAST_SLOT) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == LAST_SLOT) ? '0 : rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

// File: design/rfid_tag_controller.sv
// Tag controller: Manchester transmitter, sleep timer and contact programming port
// Operation
// - Switch on cloaks, off uncloaks antenna
// - One: uncloak then cloak, 7 us each
// - Zero: cloak then uncloak, 7 us each
// - Stream 154 memory bits Manchester-encoded
// - Randomised ~100 ms sleep, held cloaked
// - Internal reset until supply is sufficient
// - Oscillator clock sets bit timing
// - Sample program data on clock rise
// - Run mode once tenth bit arrives
// - Clock high then high voltage exits
// - New mode accepted after function ends
// - Code 0111010100 erases memory
// - Code 0111010010 programs memory
// - Code 0111010110 reads memory back
// - Sleep follows the complete transmission
// - Transmit and sleep repeat while powered
`timescale 1ns/1ps
module rfid_tag_controller
    import rfid_tag_pkg::*;
#(
    parameter int unsigned SLEEP_MIN = SLEEP_MIN_CYC,
    parameter int unsigned SLEEP_SPAN = SLEEP_SPAN_CYC,
    parameter logic [15:0] LFSR_SEED = LFSR_SEED_DEF,
    parameter logic [MEM_BITS-1:0] MEM_INIT = '0
) (
    // Clock and power-on reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Supply monitor
    input wire logic i_supply_ok,
    // Contact programming pads
    input wire logic i_prg_clk,
    input wire logic i_prg_data,
    input wire logic i_prg_hv,
    output logic o_prg_data,
    output logic o_prg_data_oe,
    // Antenna modulation and status
    output logic o_mod_switch,
    output logic o_prog_active
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic mode_t mode_of(input logic [CODE_BITS-1:0] code);
        mode_t m;
        m = MODE_NONE;
        if (code == CODE_ERASE) begin
            m = MODE_ERASE;
        end else if (code == CODE_PROGRAM) begin
            m = MODE_PROGRAM;
        end else if (code == CODE_READ) begin
            m = MODE_READ;
        end
        return m;
    endfunction

    function automatic logic [SLEEP_W-1:0] rand_sleep(input logic [15:0] r);
        logic [47:0] prod;
        prod = 48'(r) * 48'(SLEEP_SPAN);
        return SLEEP_W'(48'(SLEEP_MIN) + (prod >> 16));
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SY_N-1:0] sy1_ff;
    logic [SY_N-1:0] sy2_ff;
    logic [SY_N-1:0] sy3_ff;
    logic [SY_N-1:0] filt_ff;
    logic [SY_N-1:0] filt_d_ff;
    logic pclk_rise;
    logic hv_rise;
    logic run_ok;

    // A pad change counts only once stages two and three agree
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sy1_ff <= '0;
            sy2_ff <= '0;
            sy3_ff <= '0;
            filt_ff <= '0;
            filt_d_ff <= '0;
        end else begin
            sy1_ff <= {i_prg_hv, i_prg_data, i_prg_clk, i_supply_ok};
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
            filt_ff <= (sy2_ff & sy3_ff) | (filt_ff & (sy2_ff | sy3_ff));
            filt_d_ff <= filt_ff;
        end
    end

    assign pclk_rise = filt_ff[SY_PCLK] && !filt_d_ff[SY_PCLK];
    assign hv_rise = filt_ff[SY_HV] && !filt_d_ff[SY_HV];
    assign run_ok = filt_ff[SY_SUPPLY];

    // ------------------------------------------------------------
    // Programming port
    // ------------------------------------------------------------
    prog_state_t pf_ff;
    logic prog_active_ff;
    logic [CODE_BITS-1:0] code_ff;
    logic [3:0] code_cnt_ff;
    logic [MEM_PTR_W-1:0] pptr_ff;
    logic [MEM_BITS-1:0] mem_ff = MEM_INIT;
    logic [CODE_BITS-1:0] code_word;
    logic code_done;
    logic exit_evt;
    mode_t new_mode;

    // Leftmost code bit arrives first, so it ends up in the top bit
    assign code_word = {code_ff[CODE_BITS-2:0], filt_ff[SY_PDATA]};
    assign code_done = pclk_rise && (pf_ff == PF_CODE) && (code_cnt_ff == CODE_LAST);
    assign new_mode = code_done ? mode_of(code_word) : MODE_NONE;
    // Clock already high when high voltage appears on the data pad
    assign exit_evt = hv_rise && filt_ff[SY_PCLK];

    // Mode code collector; a wrong pattern is dropped and collection restarts
    always_ff @(posedge i_clk) begin
        if (i_reset || exit_evt || pf_ff != PF_CODE) begin
            code_ff <= '0;
            code_cnt_ff <= '0;
        end else if (pclk_rise) begin
            code_ff <= code_word;
            code_cnt_ff <= (code_cnt_ff == CODE_LAST) ? 4'h0 : code_cnt_ff + 4'h1;
        end
    end

    // Function sequencer: starts right after the tenth bit
    always_ff @(posedge i_clk) begin
        if (i_reset || exit_evt) begin
            pf_ff <= PF_CODE;
            prog_active_ff <= 1'b0;
            pptr_ff <= '0;
        end else begin
            unique case (pf_ff)
                PF_CODE: begin
                    pptr_ff <= '0;
                    if (new_mode != MODE_NONE) begin
                        prog_active_ff <= 1'b1;
                    end
                    if (new_mode == MODE_PROGRAM) begin
                        pf_ff <= PF_PROGRAM;
                    end else if (new_mode == MODE_READ) begin
                        pf_ff <= PF_READ;
                    end
                end
                PF_PROGRAM, PF_READ: begin
                    if (pclk_rise) begin
                        pptr_ff <= pptr_ff + 1'b1;
                        if (pptr_ff == MEM_LAST) begin
                            pf_ff <= PF_CODE;
                        end
                    end
                end
                default: begin
                    pf_ff <= PF_CODE;
                end
            endcase
        end
    end

    // Non-volatile array: reset leaves contents alone
    always_ff @(posedge i_clk) begin
        if (!i_reset) begin
            if (new_mode == MODE_ERASE) begin
                mem_ff <= '0;
            end else if (pf_ff == PF_PROGRAM && pclk_rise && !exit_evt) begin
                mem_ff[pptr_ff] <= filt_ff[SY_PDATA];
            end
        end
    end

    // Read-back drives the data pad while the read function runs
    always_ff @(posedge i_clk) begin
        if (i_reset || exit_evt) begin
            o_prg_data <= 1'b0;
            o_prg_data_oe <= 1'b0;
        end else begin
            o_prg_data <= (pf_ff == PF_READ) ? mem_ff[pptr_ff] : 1'b0;
            o_prg_data_oe <= (pf_ff == PF_READ);
        end
    end

    assign o_prog_active = prog_active_ff;

    // ------------------------------------------------------------
    // Transmit sequencer
    // ------------------------------------------------------------
    tx_state_t tx_state_ff;
    logic [SLEEP_W-1:0] sleep_cnt_ff;
    logic [15:0] lfsr_ff;
    logic int_reset;
    logic cell_end;
    logic enc_busy_ff;
    logic enc_half_ff;
    logic [HALF_CNT_W-1:0] enc_cnt_ff;
    tx_bit_t cur_ff;
    logic half_end;

    // Hold the transmitter in reset until the supply is good enough; the programming port and LFSR keep running
    assign int_reset = i_reset || !run_ok;

    // Free-running LFSR gives each tag its own sleep length
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lfsr_ff <= LFSR_SEED;
        end else begin
            lfsr_ff <= lfsr_ff[0] ? ((lfsr_ff >> 1) ^ LFSR_TAPS) : (lfsr_ff >> 1);
        end
    end

    // Send, sleep, send again for as long as the field lasts
    always_ff @(posedge i_clk) begin
        if (int_reset || prog_active_ff) begin
            tx_state_ff <= TX_IDLE;
            sleep_cnt_ff <= '0;
        end else begin
            unique case (tx_state_ff)
                TX_IDLE: begin
                    tx_state_ff <= TX_SEND;
                end
                TX_SEND: begin
                    if (cell_end && cur_ff.last) begin
                        tx_state_ff <= TX_SLEEP;
                        sleep_cnt_ff <= rand_sleep(lfsr_ff);
                    end
                end
                TX_SLEEP: begin
                    if (sleep_cnt_ff == '0) begin
                        tx_state_ff <= TX_SEND;
                    end else begin
                        sleep_cnt_ff <= sleep_cnt_ff - 1'b1;
                    end
                end
                default: begin
                    tx_state_ff <= TX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Memory reader feeding the buffer
    // ------------------------------------------------------------
    logic [MEM_PTR_W-1:0] rd_idx_ff;
    logic rd_done_ff;
    logic sending;
    tx_bit_t push_bit;
    tx_bit_t pop_bit;
    logic push_ready;
    logic pop_valid;
    logic pop_take;

    assign sending = (tx_state_ff == TX_SEND);
    assign push_bit = '{last: (rd_idx_ff == MEM_LAST), data: mem_ff[rd_idx_ff]};

    // Reader runs ahead; the buffer stalls it while the encoder is busy
    always_ff @(posedge i_clk) begin
        if (int_reset || !sending) begin
            rd_idx_ff <= '0;
            rd_done_ff <= 1'b0;
        end else if (!rd_done_ff && push_ready) begin
            rd_idx_ff <= rd_idx_ff + 1'b1;
            rd_done_ff <= (rd_idx_ff == MEM_LAST);
        end
    end

    bit_buffer #(
        .WIDTH($bits(tx_bit_t)),
        .DEPTH(2)
    ) u_bit_buffer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_flush(!sending),
        .i_valid(sending && !rd_done_ff),
        .i_data(push_bit),
        .o_ready(push_ready),
        .o_valid(pop_valid),
        .o_data(pop_bit),
        .i_ready(pop_take)
    );

    // ------------------------------------------------------------
    // Manchester encoder
    // ------------------------------------------------------------
    assign half_end = enc_busy_ff && (enc_cnt_ff == HALF_CNT_W'(HALF_BIT_CYC - 1));
    assign cell_end = half_end && enc_half_ff;
    // Next bit is taken on the last cycle of a cell, so cells abut with no gap
    assign pop_take = sending && pop_valid && (!enc_busy_ff || cell_end);

    always_ff @(posedge i_clk) begin
        if (int_reset || !sending) begin
            enc_busy_ff <= 1'b0;
            enc_half_ff <= 1'b0;
            enc_cnt_ff <= '0;
            cur_ff <= '0;
        end else if (pop_take) begin
            enc_busy_ff <= 1'b1;
            enc_half_ff <= 1'b0;
            enc_cnt_ff <= '0;
            cur_ff <= pop_bit;
        end else if (cell_end) begin
            enc_busy_ff <= 1'b0;
            enc_half_ff <= 1'b0;
            enc_cnt_ff <= '0;
        end else if (half_end) begin
            enc_half_ff <= 1'b1;
            enc_cnt_ff <= '0;
        end else if (enc_busy_ff) begin
            enc_cnt_ff <= enc_cnt_ff + 1'b1;
        end
    end

    // Switch high means cloaked; registered so the pad never glitches
    always_ff @(posedge i_clk) begin
        if (int_reset || prog_active_ff) begin
            o_mod_switch <= 1'b0;
        end else if (tx_state_ff == TX_SLEEP) begin
            o_mod_switch <= 1'b1;
        end else if (sending && enc_busy_ff) begin
            o_mod_switch <= enc_half_ff ? cur_ff.data : !cur_ff.data;
        end else begin
            o_mod_switch <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_one_shape;
        @(posedge i_clk) disable iff (i_reset)
        (!int_reset && !prog_active_ff && sending && enc_busy_ff && cur_ff.data)
            |=> (o_mod_switch == $past(enc_half_ff));
    endproperty
    a_one_shape: assert property (p_one_shape) else $error("one bit shape wrong");

    property p_zero_shape;
        @(posedge i_clk) disable iff (i_reset)
        (!int_reset && !prog_active_ff && sending && enc_busy_ff && !cur_ff.data)
            |=> (o_mod_switch == !$past(enc_half_ff));
    endproperty
    a_zero_shape: assert property (p_zero_shape) else $error("zero bit shape wrong");

    property p_half_len;
        @(posedge i_clk) disable iff (i_reset)
        $rose(enc_half_ff) |-> ($past(enc_cnt_ff) == HALF_CNT_W'(HALF_BIT_CYC - 1));
    endproperty
    a_half_len: assert property (p_half_len) else $error("half cell length wrong");

    property p_sleep_cloak;
        @(posedge i_clk) disable iff (i_reset)
        (tx_state_ff == TX_SLEEP && !int_reset && !prog_active_ff) |=> o_mod_switch;
    endproperty
    a_sleep_cloak: assert property (p_sleep_cloak) else $error("not cloaked in sleep");

    property p_last_sleep;
        @(posedge i_clk) disable iff (i_reset)
        (!int_reset && !prog_active_ff && sending && cell_end && cur_ff.last)
            |=> (tx_state_ff == TX_SLEEP) ##1 (sleep_cnt_ff >= SLEEP_W'(SLEEP_MIN - 1));
    endproperty
    a_last_sleep: assert property (p_last_sleep) else $error("no sleep after last bit");

    property p_supply_hold;
        @(posedge i_clk) disable iff (i_reset)
        !run_ok |=> (tx_state_ff == TX_IDLE) && !o_mod_switch;
    endproperty
    a_supply_hold: assert property (p_supply_hold) else $error("ran without supply");

    property p_prog_quiet;
        @(posedge i_clk) disable iff (i_reset)
        prog_active_ff |=> !o_mod_switch && (tx_state_ff == TX_IDLE);
    endproperty
    a_prog_quiet: assert property (p_prog_quiet) else $error("transmit during programming");

    property p_code_start;
        @(posedge i_clk) disable iff (i_reset)
        (code_done && !exit_evt && mode_of(code_word) != MODE_NONE) |=> prog_active_ff;
    endproperty
    a_code_start: assert property (p_code_start) else $error("valid code not executed");

    property p_exit;
        @(posedge i_clk) disable iff (i_reset)
        exit_evt |=> !prog_active_ff && (pf_ff == PF_CODE) && !o_prg_data_oe;
    endproperty
    a_exit: assert property (p_exit) else $error("exit ignored");

    property p_prog_write;
        @(posedge i_clk) disable iff (i_reset)
        (pf_ff == PF_PROGRAM && pclk_rise && !exit_evt)
            |=> (mem_ff[$past(pptr_ff)] == $past(filt_ff[SY_PDATA]));
    endproperty
    a_prog_write: assert property (p_prog_write) else $error("programmed bit lost");

    property p_read_done;
        @(posedge i_clk) disable iff (i_reset)
        (pf_ff == PF_READ && pclk_rise && pptr_ff == MEM_LAST && !exit_evt) |=> (pf_ff == PF_CODE);
    endproperty
    a_read_done: assert property (p_read_done) else $error("no return after read");

endmodule

// File: bench/prog_pad_model.sv
// Contact programmer model driving the tag's programming pads
`timescale 1ns/1ps
module prog_pad_model (
    // Time base
    input wire logic i_clk,
    // Pad drive
    output logic o_pclk,
    output logic o_pdata,
    output logic o_pdata_oe,
    output logic o_hv
);
    // Each level held 5 cycles, above the tag's 2-cycle pad filter
    localparam int PH = 5;

    // Power up with every pad at ground
    initial begin
        o_pclk = 1'b0;
        o_pdata = 1'b0;
        o_pdata_oe = 1'b0;
        o_hv = 1'b0;
    end

    // One clock pulse, data set up while the clock is low
    task automatic send_bit(input logic b, input logic drive);
        @(posedge i_clk);
        o_pclk <= 1'b0;
        o_pdata <= b;
        o_pdata_oe <= drive;
        repeat (PH) @(posedge i_clk);
        o_pclk <= 1'b1;
        repeat (PH) @(posedge i_clk);
        o_pclk <= 1'b0;
    endtask

    // Mode code, leftmost bit first, pad released afterwards for read-back
    task automatic send_code(input logic [9:0] code);
        for (int i = 9; i >= 0; i--) begin
            send_bit(code[i], 1'b1);
        end
        @(posedge i_clk);
        o_pdata_oe <= 1'b0;
    endtask

    // Alternative exit: clock high first, then high voltage on the data pad
    task automatic exit_hv();
        @(posedge i_clk);
        o_pclk <= 1'b1;
        repeat (PH) @(posedge i_clk);
        o_hv <= 1'b1;
        repeat (PH) @(posedge i_clk);
        o_hv <= 1'b0;
        o_pclk <= 1'b0;
    endtask
endmodule

// File: bench/rfid_tag_controller_test.sv
// Self-checking bench for the tag controller: programming port and transmit frame
`timescale 1ns/1ps
module rfid_tag_controller_test;
    import rfid_tag_pkg::*;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    // Short sleep so a whole frame plus sleep fits in one run
    localparam int unsigned S_MIN = 200;
    localparam int unsigned S_SPAN = 100;
    localparam int unsigned HALF = 280;
    localparam int unsigned CEIL = 110000;
    localparam logic [MEM_BITS-1:0] PAT_A = {7{22'h2A_5C3E}};
    localparam logic [MEM_BITS-1:0] PAT_B = {7{22'h15_A3C2}};
    logic clk;
    logic reset;
    logic supply_ok;
    logic pad_data;
    logic prg_q;
    logic prg_oe;
    logic mod_sw;
    logic prog_act;
    logic m_clk;
    logic m_data;
    logic m_oe;
    logic m_hv;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    // Pad level: tag drive wins, else programmer, else the pull-down
    assign pad_data = prg_oe ? prg_q : (m_oe ? m_data : 1'b0);

    rfid_tag_controller #(.SLEEP_MIN(S_MIN), .SLEEP_SPAN(S_SPAN),
        .MEM_INIT(PAT_A)) rfid_tag_controller_inst (.i_clk(clk), .i_reset(reset),
        .i_supply_ok(supply_ok), .i_prg_clk(m_clk), .i_prg_data(pad_data), .i_prg_hv(m_hv),
        .o_prg_data(prg_q), .o_prg_data_oe(prg_oe), .o_mod_switch(mod_sw), .o_prog_active(prog_act));
    prog_pad_model prog_pad_model_inst (.i_clk(clk), .o_pclk(m_clk), .o_pdata(m_data),
        .o_pdata_oe(m_oe), .o_hv(m_hv));

    // Time base, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Read-back after the read code: one stored bit per clock rise
    task automatic read_check(input logic [MEM_BITS-1:0] exp);
        prog_pad_model_inst.send_code(10'h1D6);
        settle(6);
        check_bit("prog_active", 1'b1, prog_act);
        check_bit("data_oe", 1'b1, prg_oe);
        check_bit("switch_in_prog", 1'b0, mod_sw);
        for (int k = 0; k < MEM_BITS; k++) begin
            check_bit("read_data", exp[k], prg_q);
            prog_pad_model_inst.send_bit(1'b0, 1'b0);
            settle(3);
        end
        check_bit("data_oe_done", 1'b0, prg_oe);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_codes();
        prog_pad_model_inst.send_code(10'h1D5);
        settle(6);
        check_bit("bad_code", 1'b0, prog_act);
        read_check(PAT_A);
        prog_pad_model_inst.send_code(10'h1D4);
        settle(6);
        read_check('0);
        prog_pad_model_inst.send_code(10'h1D2);
        for (int k = 0; k < MEM_BITS; k++) begin
            prog_pad_model_inst.send_bit(PAT_B[k], 1'b1);
        end
        settle(6);
        read_check(PAT_B);
    endtask

    // Both exits, with re-entry in between
    task automatic t_exits();
        prog_pad_model_inst.send_code(10'h1D6);
        prog_pad_model_inst.exit_hv();
        settle(6);
        check_bit("hv_exit", 1'b0, prog_act);
        check_bit("hv_exit_oe", 1'b0, prg_oe);
        prog_pad_model_inst.send_code(10'h1D6);
        settle(6);
        check_bit("reentry", 1'b1, prog_act);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        settle(1);
        check_bit("power_exit", 1'b0, prog_act);
    endtask

    // Full frame, sleep, and start of the next frame
    task automatic t_frame(input logic [MEM_BITS-1:0] exp);
        int n;
        @(posedge clk);
        supply_ok <= 1'b0;
        settle(10);
        check_bit("switch_unpowered", 1'b0, mod_sw);
        @(posedge clk);
        supply_ok <= 1'b1;
        n = 0;
        // Sample on the falling edge so the switch has settled
        while (mod_sw !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        repeat (HALF / 2 - 1) @(negedge clk);
        for (int k = 0; k < MEM_BITS; k++) begin
            check_bit("cell_first", ~exp[k], mod_sw);
            repeat (HALF) @(negedge clk);
            check_bit("cell_second", exp[k], mod_sw);
            repeat (HALF) @(negedge clk);
        end
        // Now 140 cycles into the sleep; only the shortest sleep is certain to be cloaked
        n = 0;
        repeat (S_MIN - HALF / 2) begin
            if (mod_sw !== 1'b1) n++;
            @(negedge clk);
        end
        check_bit("sleep_cloaked", 1'b1, n == 0);
        n = 0;
        while (mod_sw !== 1'b0 && n < S_SPAN + 40) begin
            @(negedge clk);
            n++;
        end
        // Two uncloaked cycles while the buffer refills, then the first cell again
        check_bit("next_frame", 1'b0, mod_sw);
        repeat (HALF / 2) @(negedge clk);
        check_bit("next_first", ~exp[0], mod_sw);
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        supply_ok = 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        settle(1);
        check_bit("rst_switch", 1'b0, mod_sw);
        check_bit("rst_oe", 1'b0, prg_oe);
        check_bit("rst_prog", 1'b0, prog_act);
        t_codes();
        t_exits();
        t_frame(PAT_B);
        close_out();
    end
endmodule
